/* File: src/ucf_defs.svh */
`ifndef UCF_DEFS_SVH
`define UCF_DEFS_SVH

`define UCF_START_BYTE   8'h02
`define UCF_END_BYTE     8'h03
`define UCF_TYPE_REQUEST 8'h52
`define UCF_TYPE_CONFIRM 8'h43
`define UCF_TYPE_INDICAT 8'h69
`define UCF_TYPE_RESPONS 8'h72
`define UCF_MAX_PAYLOAD  16'd333
`define UCF_LEN_W        16
`define UCF_PWR_W        3

`endif

/* File: src/ucf_pkg.sv */
package ucf_pkg;
   typedef enum logic [2:0] {
      UCF_RADIO_OFF  = 3'b001,
      UCF_RADIO_SCAN = 3'b010,
      UCF_RADIO_LINK = 3'b100
   } ucf_radio_e;

   typedef enum logic [2:0] {
      power_state_all_off        = 3'd0,
      power_state_uart_only      = 3'd1,
      power_state_scan_uart_off  = 3'd2,
      power_state_scan_uart_on   = 3'd3,
      power_state_link_uart_off  = 3'd4,
      power_state_link_uart_on   = 3'd5
   } ucf_power_e;
endpackage

/* File: src/ucf_tx_framer.sv */
`timescale 1ns/1ps
`include "ucf_defs.svh"
// serialises one frame: start, type, opcode, len lsb, len msb, sum, data, end
module ucf_tx_framer (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        start,
   input  wire logic [7:0]  pkt_type,
   input  wire logic [7:0]  opcode,
   input  wire logic [15:0] length,
   input  wire logic [7:0]  pl_data,
   output logic             pl_take,
   output logic [7:0]       byte_data,
   output logic             byte_valid,
   input  wire logic        byte_ready,
   output logic             busy
);
   typedef enum logic [8:0] {
      TX_IDLE = 9'b0_0000_0001, TX_TYPE = 9'b0_0000_0010,
      TX_OPC  = 9'b0_0000_0100, TX_LENL = 9'b0_0000_1000,
      TX_LENH = 9'b0_0001_0000, TX_SUM  = 9'b0_0010_0000,
      TX_DATA = 9'b0_0100_0000, TX_END  = 9'b0_1000_0000,
      TX_STX  = 9'b1_0000_0000
   } ucf_tx_e;
   ucf_tx_e     st_ff, nxt_st;
   logic [7:0]  typ_ff, nxt_typ, opc_ff, nxt_opc;
   logic [15:0] len_ff, nxt_len, cnt_ff, nxt_cnt;
   logic [7:0]  sum;
   logic        adv;

   assign sum = 8'(typ_ff + opc_ff + len_ff[7:0] + len_ff[15:8]);
   assign adv = byte_ready;
   assign busy = (st_ff != TX_IDLE);
   assign byte_valid = busy;
   assign pl_take = (st_ff == TX_DATA) && adv;

   always_comb begin
      unique case (st_ff)
         TX_TYPE: byte_data = typ_ff;
         TX_OPC:  byte_data = opc_ff;
         TX_LENL: byte_data = len_ff[7:0];
         TX_LENH: byte_data = len_ff[15:8];
         TX_SUM:  byte_data = sum;
         TX_DATA: byte_data = pl_data;
         TX_END:  byte_data = `UCF_END_BYTE;
         default: byte_data = `UCF_START_BYTE;
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_typ = typ_ff;
      nxt_opc = opc_ff;
      nxt_len = len_ff;
      nxt_cnt = cnt_ff;
      unique case (st_ff)
         TX_IDLE: if (start) begin
            nxt_typ = pkt_type;
            nxt_opc = opcode;
            nxt_len = (length > `UCF_MAX_PAYLOAD) ? `UCF_MAX_PAYLOAD
                                                  : length;
            nxt_st  = TX_STX;
         end
         TX_STX:  if (adv) nxt_st = TX_TYPE;
         TX_TYPE: if (adv) nxt_st = TX_OPC;
         TX_OPC:  if (adv) nxt_st = TX_LENL;
         TX_LENL: if (adv) nxt_st = TX_LENH;
         TX_LENH: if (adv) nxt_st = TX_SUM;
         TX_SUM:  if (adv) begin
            nxt_cnt = len_ff;
            nxt_st = (len_ff == 16'h0000) ? TX_END : TX_DATA;
         end
         TX_DATA: if (adv) begin
            nxt_cnt = cnt_ff - 16'h0001;
            if (cnt_ff == 16'h0001) nxt_st = TX_END;
         end
         TX_END:  if (adv) nxt_st = TX_IDLE;
         default: nxt_st = TX_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st_ff  <= TX_IDLE;
         typ_ff <= 8'h00;
         opc_ff <= 8'h00;
         len_ff <= 16'h0000;
         cnt_ff <= 16'h0000;
      end else begin
         st_ff  <= nxt_st;
         typ_ff <= nxt_typ;
         opc_ff <= nxt_opc;
         len_ff <= nxt_len;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule

/* File: src/ucf_framer.sv */
`timescale 1ns/1ps
`include "ucf_defs.svh"
// What this block does
// - frames begin with byte 02 and end with byte 03
// - field order: start, type, opcode, two length bytes, sum, data, end
// - payload length never above 333 bytes
// - checksum is low byte of type+opcode+length bytes, payload excluded
// - opcode passes through unchanged beside the packet type
// - each received request gets exactly one confirm, type 43
// - unsolicited events go out as indications, type 69
// - transparent mode passes bytes straight through, no parsing
// - transport comes up enabled after reset
// - only host disable command turns transport off; wake turns it on
// - on disable: send confirm, drain, then shut uart down
// - while disabled, a falling cts edge wakes the transport
// - to send while disabled, assert rts to wake the host
// - module wake: after host rts, empty indication event first, then pending
// - host rts while disabled: enable uart and assert own rts
// - host wake: send transport enabled event
// - power state combines uart activity and radio activity
module ucf_framer
   import ucf_pkg::*;
#(
   parameter int MAX_PAYLOAD = 333
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_valid,
   input  wire logic        rx_break,
   output logic [7:0]       tx_byte,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   input  wire logic        cts_n,
   output logic             rts_n,
   output logic             uart_enabled,
   output logic [7:0]       cmd_type,
   output logic [7:0]       cmd_opcode,
   output logic [15:0]      cmd_length,
   output logic             cmd_valid,
   output logic [7:0]       cmd_data,
   output logic             cmd_data_valid,
   output logic             frame_error,
   input  wire logic        disable_cmd,
   input  wire logic        transparent_req,
   output logic             transparent,
   output logic [7:0]       link_byte,
   output logic             link_valid,
   input  wire logic        cfm_req,
   input  wire logic        ind_req,
   input  wire logic [7:0]  ans_opcode,
   input  wire logic [15:0] ans_length,
   input  wire logic [7:0]  ans_data,
   output logic             ans_take,
   output logic             ans_done,
   input  wire logic        wake_cfm_opcode_sel,
   input  wire logic [7:0]  wake_opcode,
   input  ucf_pkg::ucf_radio_e radio_state,
   output ucf_pkg::ucf_power_e power_state
);
   import ucf_pkg::*;

   initial begin
      if (MAX_PAYLOAD < 1 || MAX_PAYLOAD > 65535)
         $error("payload limit out of range");
   end

   typedef enum logic [7:0] {
      RX_HUNT = 8'b0000_0001, RX_TYPE = 8'b0000_0010,
      RX_OPC  = 8'b0000_0100, RX_LENL = 8'b0000_1000,
      RX_LENH = 8'b0001_0000, RX_SUM  = 8'b0010_0000,
      RX_DATA = 8'b0100_0000, RX_END  = 8'b1000_0000
   } ucf_rx_e;

   typedef enum logic [4:0] {
      TP_ON    = 5'b0_0001,
      TP_DRAIN = 5'b0_0010,
      TP_OFF   = 5'b0_0100,
      TP_WAKE  = 5'b0_1000,
      TP_EVENT = 5'b1_0000
   } ucf_tp_e;

   // receive parser state
   ucf_rx_e     rx_ff, nxt_rx;
   logic [7:0]  typ_ff, nxt_typ, opc_ff, nxt_opc;
   logic [15:0] len_ff, nxt_len, cnt_ff, nxt_cnt;
   logic        ok_ff, nxt_ok;
   logic        cv_ff, nxt_cv, dv_ff, nxt_dv, fe_ff, nxt_fe;
   logic [7:0]  dat_ff, nxt_dat;
   logic        req_pend_ff, nxt_req_pend;
   // transparent path
   logic        tm_ff, nxt_tm;
   logic [7:0]  lb_ff, nxt_lb;
   logic        lv_ff, nxt_lv;
   // transport control
   ucf_tp_e     tp_ff, nxt_tp;
   logic        rts_n_ff, nxt_rts_n;
   logic        en_ff, nxt_en;
   logic        cts_d_ff, nxt_cts_d;
   logic        host_wake_ff, nxt_host_wake;
   logic        pend_ff, nxt_pend;
   ucf_power_e  pw_ff, nxt_pw;
   // transmitter
   logic        tx_start;
   logic [7:0]  tx_type, tx_opc;
   logic [15:0] tx_len;
   logic        tx_busy, pl_take;
   logic [7:0]  fr_byte;
   logic        fr_valid, fr_ready;
   logic        tbv_ff, nxt_tbv;
   logic [7:0]  tb_ff, nxt_tb;
   logic        busy_d_ff, nxt_busy_d;
   logic        ans_done_ff, nxt_ans_done;
   logic        ans_take_ff;
   logic [7:0]  sum_now;

   assign sum_now = 8'(typ_ff + opc_ff + len_ff[7:0] + len_ff[15:8]);

   // receive parser
   always_comb begin
      nxt_rx  = rx_ff;
      nxt_typ = typ_ff;
      nxt_opc = opc_ff;
      nxt_len = len_ff;
      nxt_cnt = cnt_ff;
      nxt_ok  = ok_ff;
      nxt_cv  = 1'b0;
      nxt_dv  = 1'b0;
      nxt_fe  = 1'b0;
      nxt_dat = dat_ff;
      nxt_req_pend = req_pend_ff;
      if (cfm_req && !tx_busy && !tbv_ff && tp_ff == TP_ON)
         nxt_req_pend = 1'b0;
      if (tm_ff || !en_ff) begin
         nxt_rx = RX_HUNT;
      end else if (rx_valid) begin
         unique case (rx_ff)
            RX_HUNT: if (rx_byte == `UCF_START_BYTE) nxt_rx = RX_TYPE;
            RX_TYPE: begin
               nxt_typ = rx_byte;
               nxt_rx = RX_OPC;
            end
            RX_OPC: begin
               nxt_opc = rx_byte;
               nxt_rx = RX_LENL;
            end
            RX_LENL: begin
               nxt_len = {8'h00, rx_byte};
               nxt_rx = RX_LENH;
            end
            RX_LENH: begin
               nxt_len = {rx_byte, len_ff[7:0]};
               nxt_rx = RX_SUM;
            end
            RX_SUM: begin
               nxt_cnt = len_ff;
               if (rx_byte != sum_now || len_ff > 16'(MAX_PAYLOAD)) begin
                  nxt_fe = 1'b1;
                  nxt_rx = RX_HUNT;
               end else begin
                  nxt_rx = (len_ff == 16'h0000) ? RX_END : RX_DATA;
               end
            end
            RX_DATA: begin
               nxt_dat = rx_byte;
               nxt_dv  = 1'b1;
               nxt_cnt = cnt_ff - 16'h0001;
               if (cnt_ff == 16'h0001) nxt_rx = RX_END;
            end
            RX_END: begin
               nxt_rx = RX_HUNT;
               if (rx_byte == `UCF_END_BYTE) begin
                  nxt_cv = 1'b1;
                  if (typ_ff == `UCF_TYPE_REQUEST)
                     nxt_req_pend = 1'b1;
               end else begin
                  nxt_fe = 1'b1;
               end
            end
            default: nxt_rx = RX_HUNT;
         endcase
      end
   end

   // transparent pass
   always_comb begin
      nxt_tm = tm_ff;
      nxt_lb = lb_ff;
      nxt_lv = 1'b0;
      if (tm_ff) begin
         if (rx_break) nxt_tm = 1'b0;
         else if (rx_valid) begin
            nxt_lb = rx_byte;
            nxt_lv = 1'b1;
         end
      end else if (transparent_req && en_ff) begin
         nxt_tm = 1'b1;
      end
   end

   // transport / wake control
   always_comb begin
      nxt_tp = tp_ff;
      nxt_rts_n = rts_n_ff;
      nxt_en = en_ff;
      nxt_cts_d = cts_n;
      nxt_host_wake = host_wake_ff;
      nxt_pend = pend_ff;
      tx_start = 1'b0;
      tx_type = `UCF_TYPE_CONFIRM;
      tx_opc = ans_opcode;
      tx_len = ans_length;
      unique case (tp_ff)
         TP_ON: begin
            nxt_rts_n = 1'b0;
            if (!tx_busy && !tbv_ff) begin
               if (cfm_req && req_pend_ff) begin
                  tx_start = 1'b1;
                  if (disable_cmd) nxt_tp = TP_DRAIN;
               end else if (ind_req) begin
                  tx_type = `UCF_TYPE_INDICAT;
                  tx_start = 1'b1;
               end
            end
         end
         TP_DRAIN: begin
            if (!tx_busy && !tbv_ff && !busy_d_ff) begin
               nxt_en = 1'b0;
               nxt_rts_n = 1'b1;
               nxt_tp = TP_OFF;
            end
         end
         TP_OFF: begin
            if (cts_d_ff && !cts_n) begin
               nxt_en = 1'b1;
               nxt_rts_n = 1'b0;
               nxt_host_wake = !pend_ff;
               nxt_tp = TP_EVENT;
            end else if (ind_req) begin
               nxt_pend = 1'b1;
               nxt_rts_n = 1'b0;
               nxt_tp = TP_WAKE;
            end
         end
         TP_WAKE: begin
            if (!cts_n) begin
               nxt_en = 1'b1;
               nxt_host_wake = 1'b0;
               nxt_tp = TP_EVENT;
            end
         end
         TP_EVENT: begin
            tx_type = `UCF_TYPE_INDICAT;
            tx_opc = wake_cfm_opcode_sel ? wake_opcode : ans_opcode;
            tx_len = 16'h0000;
            if (!tx_busy && !tbv_ff) begin
               tx_start = 1'b1;
               nxt_pend = 1'b0;
               nxt_host_wake = 1'b0;
               nxt_tp = TP_ON;
            end
         end
         default: nxt_tp = TP_ON;
      endcase
   end

   always_comb begin
      unique case (radio_state)
         UCF_RADIO_SCAN: nxt_pw = en_ff ? power_state_scan_uart_on
                                        : power_state_scan_uart_off;
         UCF_RADIO_LINK: nxt_pw = en_ff ? power_state_link_uart_on
                                        : power_state_link_uart_off;
         default:        nxt_pw = en_ff ? power_state_uart_only
                                        : power_state_all_off;
      endcase
   end

   ucf_tx_framer u_tx (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .start      (tx_start),
      .pkt_type   (tx_type),
      .opcode     (tx_opc),
      .length     (tx_len),
      .pl_data    (ans_data),
      .pl_take    (pl_take),
      .byte_data  (fr_byte),
      .byte_valid (fr_valid),
      .byte_ready (fr_ready),
      .busy       (tx_busy)
   );

   // output register stage towards the uart
   // pause one cycle after each take so ans_data can step
   assign fr_ready = (!tbv_ff || tx_ready) && !ans_take_ff;
   always_comb begin
      nxt_tbv = tbv_ff;
      nxt_tb = tb_ff;
      if (tbv_ff && tx_ready) nxt_tbv = 1'b0;
      if (fr_valid && fr_ready) begin
         nxt_tbv = 1'b1;
         nxt_tb = fr_byte;
      end
      nxt_busy_d = tx_busy;
      nxt_ans_done = busy_d_ff && !tx_busy;
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rx_ff <= RX_HUNT;
         typ_ff <= 8'h00;
         opc_ff <= 8'h00;
         len_ff <= 16'h0000;
         cnt_ff <= 16'h0000;
         ok_ff <= 1'b0;
         cv_ff <= 1'b0;
         dv_ff <= 1'b0;
         fe_ff <= 1'b0;
         dat_ff <= 8'h00;
         req_pend_ff <= 1'b0;
         tm_ff <= 1'b0;
         lb_ff <= 8'h00;
         lv_ff <= 1'b0;
         tp_ff <= TP_ON;
         rts_n_ff <= 1'b0;
         en_ff <= 1'b1;
         cts_d_ff <= 1'b1;
         host_wake_ff <= 1'b0;
         pend_ff <= 1'b0;
         pw_ff <= power_state_uart_only;
         tbv_ff <= 1'b0;
         tb_ff <= 8'h00;
         busy_d_ff <= 1'b0;
         ans_done_ff <= 1'b0;
         ans_take_ff <= 1'b0;
      end else begin
         rx_ff <= nxt_rx;
         typ_ff <= nxt_typ;
         opc_ff <= nxt_opc;
         len_ff <= nxt_len;
         cnt_ff <= nxt_cnt;
         ok_ff <= nxt_ok;
         cv_ff <= nxt_cv;
         dv_ff <= nxt_dv;
         fe_ff <= nxt_fe;
         dat_ff <= nxt_dat;
         req_pend_ff <= nxt_req_pend;
         tm_ff <= nxt_tm;
         lb_ff <= nxt_lb;
         lv_ff <= nxt_lv;
         tp_ff <= nxt_tp;
         rts_n_ff <= nxt_rts_n;
         en_ff <= nxt_en;
         cts_d_ff <= nxt_cts_d;
         host_wake_ff <= nxt_host_wake;
         pend_ff <= nxt_pend;
         pw_ff <= nxt_pw;
         tbv_ff <= nxt_tbv;
         tb_ff <= nxt_tb;
         busy_d_ff <= nxt_busy_d;
         ans_done_ff <= nxt_ans_done;
         ans_take_ff <= pl_take;
      end
   end

   // ans_take is the registered payload-advance strobe; ans_data must hold
   // the current payload byte and step on the cycle after ans_take
   assign ans_take = ans_take_ff;
   assign ans_done = ans_done_ff;
   assign tx_byte = tb_ff;
   assign tx_valid = tbv_ff;
   assign rts_n = rts_n_ff;
   assign uart_enabled = en_ff;
   assign cmd_type = typ_ff;
   assign cmd_opcode = opc_ff;
   assign cmd_length = len_ff;
   assign cmd_valid = cv_ff;
   assign cmd_data = dat_ff;
   assign cmd_data_valid = dv_ff;
   assign frame_error = fe_ff;
   assign transparent = tm_ff;
   assign link_byte = lb_ff;
   assign link_valid = lv_ff;
   assign power_state = pw_ff;
endmodule

/* File: testbench/ucf_framer_assertions.sv */
`timescale 1ns/1ps
`include "ucf_defs.svh"
module ucf_framer_assertions
   import ucf_pkg::*;
#(
   parameter int MAX_PAYLOAD = 333
) (
   input wire logic       sys_clk,
   input wire logic       resetn,
   input wire logic [7:0] rx_byte,
   input wire logic       rx_valid,
   input wire logic       rx_break,
   input wire logic [7:0] tx_byte,
   input wire logic       tx_valid,
   input wire logic       tx_ready,
   input wire logic       cts_n,
   input wire logic       rts_n,
   input wire logic       uart_enabled,
   input wire logic       cmd_valid,
   input wire logic       transparent,
   input wire logic [7:0] link_byte,
   input wire logic       link_valid,
   input wire logic       ind_req,
   input ucf_pkg::ucf_radio_e radio_state,
   input ucf_pkg::ucf_power_e power_state
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic [15:0] pos_ff;
   logic [7:0]  ty_ff, op_ff, lo_ff, hi_ff;
   wire         acc = tx_valid && tx_ready;
   wire  [2:0]  exp_pwr = (radio_state == UCF_RADIO_SCAN ? 3'h2 :
                radio_state == UCF_RADIO_LINK ? 3'h4 : 3'h0) + uart_enabled;
   // byte position inside the outgoing frame
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pos_ff <= 16'h0000;
      end else if (acc) begin
         pos_ff <= (pos_ff > 16'h0005 && pos_ff == {hi_ff, lo_ff} + 16'h0006)
                   ? 16'h0000 : pos_ff + 16'h0001;
         if (pos_ff == 16'h0001) ty_ff <= tx_byte;
         if (pos_ff == 16'h0002) op_ff <= tx_byte;
         if (pos_ff == 16'h0003) lo_ff <= tx_byte;
         if (pos_ff == 16'h0004) hi_ff <= tx_byte;
      end
   end
   a_reset_values: assert property ($rose(resetn) |-> uart_enabled && !rts_n
      && !transparent && !tx_valid) else $error("bad state after reset");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid
      && $stable(tx_byte)) else $error("tx byte dropped before taken");
   a_frame_start: assert property (acc && pos_ff == 16'h0000
      |-> tx_byte == `UCF_START_BYTE) else $error("frame start byte wrong");
   a_type_legal: assert property (acc && pos_ff == 16'h0001 |->
      tx_byte == `UCF_TYPE_CONFIRM || tx_byte == `UCF_TYPE_INDICAT)
      else $error("sent packet type illegal");
   a_sum_byte: assert property (acc && pos_ff == 16'h0005 |->
      tx_byte == ty_ff + op_ff + lo_ff + hi_ff) else $error("bad checksum");
   a_len_limit: assert property (acc && pos_ff == 16'h0005 |->
      {hi_ff, lo_ff} <= MAX_PAYLOAD) else $error("payload too long");
   a_frame_end: assert property (acc && pos_ff > 16'h0005 &&
      pos_ff == {hi_ff, lo_ff} + 16'h0006 |-> tx_byte == `UCF_END_BYTE)
      else $error("end byte missing");
   a_power_map: assert property (($stable(radio_state) &&
      $stable(uart_enabled)) [*3] |-> power_state == exp_pwr)
      else $error("power state wrong");
   a_host_wake: assert property (!uart_enabled && $fell(cts_n) |->
      ##[1:2] (uart_enabled && !rts_n)) else $error("host wake ignored");
   a_module_wake: assert property (!uart_enabled && rts_n && ind_req
      |-> ##[1:3] !rts_n) else $error("module did not raise rts");
   a_off_quiet: assert property (!uart_enabled && !$past(uart_enabled)
      |-> !cmd_valid) else $error("frame parsed while disabled");
   a_link_pass: assert property (transparent && rx_valid && !rx_break
      |=> link_valid && link_byte == $past(rx_byte))
      else $error("byte not passed to link");
   a_break_exit: assert property (transparent && rx_break |->
      ##[1:2] !transparent) else $error("break did not leave mode");
endmodule
bind ucf_framer ucf_framer_assertions #(.MAX_PAYLOAD(MAX_PAYLOAD)) chk_i (
   .sys_clk, .resetn, .rx_byte, .rx_valid, .rx_break, .tx_byte, .tx_valid,
   .tx_ready, .cts_n, .rts_n, .uart_enabled, .cmd_valid, .transparent,
   .link_byte, .link_valid, .ind_req, .radio_state, .power_state);

/* File: testbench/ucf_host_model.sv */
`timescale 1ns/1ps
module ucf_host_model (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       slow,
   input  wire logic       wake_req,
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_valid,
   output logic            tx_ready = 1'b0,
   input  wire logic       rts_n,
   output logic            cts_n = 1'b1
);
   logic [7:0] got[$];
   logic       stall_ff = 1'b0;
   always @(posedge sys_clk) begin
      if (!resetn) begin
         tx_ready <= 1'b0;
         stall_ff <= 1'b0;
         cts_n    <= 1'b1;
      end else begin
         // slow host stalls every other cycle
         stall_ff <= ~stall_ff;
         tx_ready <= !slow || stall_ff;
         if (tx_valid && tx_ready)
            got.push_back(tx_byte);
         // own rts follows a wake request or mirrors the module's rts
         cts_n <= !(wake_req || !rts_n);
      end
   end
endmodule

/* File: testbench/test_ucf_framer.sv */
`timescale 1ns/1ps
`include "ucf_defs.svh"
`define CHK(g, e) chk(16'(g), 16'(e))
module test_ucf_framer;
   import ucf_pkg::*;
   logic        sys_clk = 1'b0, resetn = 1'b0, slow = 1'b0, wake_req = 1'b0;
   logic [7:0]  rx_byte = 8'h00, ans_opcode = 8'h00, ans_data = 8'h00;
   logic [7:0]  wake_opcode = 8'h00, tx_byte, cmd_type, cmd_opcode, link_byte;
   logic        rx_valid = 1'b0, rx_break = 1'b0, disable_cmd = 1'b0;
   logic        transparent_req = 1'b0, cfm_req = 1'b0, ind_req = 1'b0;
   logic        wake_cfm_opcode_sel = 1'b0, tx_ready, cts_n, tx_valid, rts_n;
   logic        uart_enabled, cmd_valid, frame_error, transparent;
   logic        link_valid, ans_take;
   logic [15:0] ans_length = 16'h0000, cmd_length;
   ucf_radio_e  radio_state = UCF_RADIO_OFF;
   ucf_power_e  power_state;
   ucf_radio_e  rad[3] = '{UCF_RADIO_OFF, UCF_RADIO_SCAN, UCF_RADIO_LINK};
   ucf_power_e  pwr[3] = '{power_state_uart_only, power_state_scan_uart_on,
                           power_state_link_uart_on};
   int          seed = 32'h6253, num_errors = 0, compares = 0;
   int          n_cmd = 0, n_err = 0;
   logic [7:0]  last_link = 8'h00, pty = `UCF_TYPE_REQUEST;

   ucf_framer #(.MAX_PAYLOAD(333)) uut (.sys_clk, .resetn, .rx_byte,
      .rx_valid, .rx_break, .tx_byte, .tx_valid, .tx_ready, .cts_n, .rts_n,
      .uart_enabled, .cmd_type, .cmd_opcode, .cmd_length, .cmd_valid,
      .cmd_data(), .cmd_data_valid(), .frame_error, .disable_cmd,
      .transparent_req, .transparent, .link_byte, .link_valid, .cfm_req,
      .ind_req, .ans_opcode, .ans_length, .ans_data, .ans_take, .ans_done(),
      .wake_cfm_opcode_sel, .wake_opcode, .radio_state, .power_state);
   ucf_host_model host (.sys_clk, .resetn, .slow, .wake_req, .tx_byte,
      .tx_valid, .tx_ready, .rts_n, .cts_n);

   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      n_cmd <= n_cmd + int'(cmd_valid === 1'b1);
      n_err <= n_err + int'(frame_error === 1'b1);
      if (link_valid === 1'b1) last_link <= link_byte;
      if (ans_take === 1'b1) ans_data <= ans_data + 8'h01;
   end

   task automatic finish_test;
      $display("compares %0d, num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, e);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic timeout;
      num_errors++;
      $display("wait limit reached at %0t", $time);
      finish_test();
   endtask
   function automatic logic [7:0] sum8(input logic [7:0] ty, op,
                                       input logic [15:0] ln);
      return ty + op + ln[7:0] + ln[15:8];
   endfunction
   task automatic send_frame(input logic [7:0] op, input logic [15:0] ln,
                             input logic bad, ok);
      logic [7:0] q[$];
      int         c0, e0;
      q = {`UCF_START_BYTE, pty, op, ln[7:0], ln[15:8]};
      q.push_back(sum8(pty, op, ln) ^ {7'h00, bad});
      for (int i = 0; i < ln; i++) q.push_back(8'($random(seed)));
      q.push_back(`UCF_END_BYTE);
      c0 = n_cmd;
      e0 = n_err;
      foreach (q[i]) begin
         rx_byte  <= q[i];
         rx_valid <= 1'b1;
         @(posedge sys_clk);
      end
      rx_valid <= 1'b0;
      tick(4);
      `CHK(n_cmd - c0, ok && !bad);
      `CHK(n_err - e0, bad);
      if (ok && !bad) begin
         `CHK(cmd_type, pty);
         `CHK(cmd_opcode, op);
         `CHK(cmd_length, ln);
      end
   endtask
   task automatic answer(input logic confirm_packet, dis, input logic [7:0] op, d0,
                         input logic [15:0] ln);
      int n;
      ans_opcode  <= op;
      ans_length  <= ln;
      ans_data    <= d0;
      disable_cmd <= dis;
      cfm_req     <= confirm_packet;
      ind_req     <= !confirm_packet;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ans_take !== 1'b1 && n < 400);
      cfm_req     <= 1'b0;
      ind_req     <= 1'b0;
      disable_cmd <= 1'b0;
      if (n == 400) timeout();
   endtask
   task automatic expect_frame(input logic [7:0] ty, op,
                               input logic [15:0] ln, input logic [7:0] d0);
      logic [7:0] e[$];
      int         n;
      e = {`UCF_START_BYTE, ty, op, ln[7:0], ln[15:8], sum8(ty, op, ln)};
      for (int i = 0; i < ln; i++) e.push_back(d0 + 8'(i));
      e.push_back(`UCF_END_BYTE);
      n = 0;
      while (host.got.size() < e.size() && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 3000) timeout();
      foreach (e[i]) `CHK(host.got.pop_front(), e[i]);
   endtask
   task automatic shut_down(input logic [7:0] op);
      int n;
      send_frame(op, 16'h0001, 1'b0, 1'b1);
      answer(1'b1, 1'b1, op, 8'h20, 16'h0002);
      expect_frame(`UCF_TYPE_CONFIRM, op, 16'h0002, 8'h20);
      n = 0;
      while (uart_enabled !== 1'b0 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      `CHK(uart_enabled, 0);
      `CHK(rts_n, 1);
   endtask

   initial begin
      logic [7:0]  op;
      logic [15:0] ln;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      tick(2);
      `CHK(uart_enabled, 1);
      `CHK(power_state, power_state_uart_only);
      $display("test reset finished");
      for (int i = 0; i < 6; i++) begin
         op = 8'($random(seed));
         ln = 16'($unsigned($random(seed)) % 6) + 16'h0001;
         slow <= i[0];
         pty = (i == 4) ? `UCF_TYPE_RESPONS : `UCF_TYPE_REQUEST;
         send_frame(op, ln, i == 2, 1'b1);
         if (i != 2 && i != 4) begin
            answer(1'b1, 1'b0, op, op ^ 8'h5a, ln);
            expect_frame(`UCF_TYPE_CONFIRM, op, ln, op ^ 8'h5a);
         end
      end
      answer(1'b0, 1'b0, 8'h3c, 8'h10, 16'h0190);
      expect_frame(`UCF_TYPE_INDICAT, 8'h3c, 16'h014d, 8'h10);
      $display("test framing finished");
      foreach (rad[i]) begin
         radio_state <= rad[i];
         tick(3);
         `CHK(power_state, pwr[i]);
      end
      transparent_req <= 1'b1;
      @(posedge sys_clk);
      transparent_req <= 1'b0;
      tick(2);
      `CHK(transparent, 1);
      repeat (3) begin
         op = 8'($random(seed));
         rx_byte  <= op;
         rx_valid <= 1'b1;
         @(posedge sys_clk);
         rx_valid <= 1'b0;
         tick(2);
         `CHK(last_link, op);
      end
      send_frame(8'h11, 16'h0001, 1'b0, 1'b0);
      rx_break <= 1'b1;
      @(posedge sys_clk);
      rx_break <= 1'b0;
      tick(2);
      `CHK(transparent, 0);
      $display("test transparent finished");
      shut_down(8'h0a);
      tick(1);
      `CHK(power_state, power_state_link_uart_off);
      send_frame(8'h12, 16'h0001, 1'b0, 1'b0);
      wake_opcode         <= 8'($random(seed));
      wake_cfm_opcode_sel <= 1'b1;
      wake_req            <= 1'b1;
      tick(5);
      `CHK(uart_enabled, 1);
      `CHK(rts_n, 0);
      expect_frame(`UCF_TYPE_INDICAT, wake_opcode, 16'h0000, 8'h00);
      wake_req <= 1'b0;
      $display("test host wake finished");
      // host stays quiet until the module raises rts
      shut_down(8'h0b);
      wake_cfm_opcode_sel <= 1'b0;
      answer(1'b0, 1'b0, 8'h44, 8'h30, 16'h0003);
      expect_frame(`UCF_TYPE_INDICAT, 8'h44, 16'h0000, 8'h00);
      expect_frame(`UCF_TYPE_INDICAT, 8'h44, 16'h0003, 8'h30);
      $display("test module wake finished");
      finish_test();
   end
endmodule
